/* File: verilog/mpcs_clock_select.sv */
// Clock source and pin direction control for the external MAC ports and the sync output.
// Assumes SYS_CLK is the internally multiplied reference at 100 MHz and all pin inputs are synchronous.
`timescale 1ns/1ps
`include "mpcs_params.svh"

module mpcs_clock_select
(
    // Clock and reset
    input  wire logic                                   SYS_CLK,
    input  wire logic                                   RESETN,
    // Register port
    input  wire logic [7:0]                             REG_ADDR,
    input  wire logic [31:0]                            REG_WDATA,
    input  wire logic                                   REG_WR,
    input  wire logic                                   REG_RD,
    output logic      [31:0]                            REG_RDATA,
    // Configuration straps
    input  wire mpcs_pkg::mpcs_strap_t [`MPCS_NPORT-1:0] STRAP,
    // MAC port clock pins
    input  wire logic [`MPCS_NPORT-1:0]                 PORT_RECEIVE_CLOCK_I,
    output logic      [`MPCS_NPORT-1:0]                 PORT_RECEIVE_CLOCK_O,
    output logic      [`MPCS_NPORT-1:0]                 PORT_RECEIVE_CLOCK_OE_N,
    input  wire logic [`MPCS_NPORT-1:0]                 PORT_TRANSMIT_CLOCK_I,
    output logic      [`MPCS_NPORT-1:0]                 PORT_TRANSMIT_CLOCK_O,
    output logic      [`MPCS_NPORT-1:0]                 PORT_TRANSMIT_CLOCK_OE_N,
    // PHY clocks and management clock
    input  wire logic [`MPCS_NPHY-1:0]                  PHY_RECOVERED_CLK,
    input  wire logic                                   SERIAL_MGMT_CLK,
    output logic                                        PHY_TX_REF_CLK,
    output logic                                        SYNC_ETH_CLOCK_OUT
);
    import mpcs_pkg::*;

    function automatic logic [5:0] mpcs_half(input int khz);
        int h;
        h = `MPCS_SYS_KHZ / (2 * khz);
        return (h < 1) ? 6'h01 : h[5:0];
    endfunction

    // Counter step: returns {toggle, next count}
    function automatic logic [6:0] mpcs_step(input logic [5:0] cnt, input logic [5:0] half);
        if (cnt + 6'h01 >= half)
            return {1'b1, 6'h00};
        return {1'b0, cnt + 6'h01};
    endfunction

    localparam logic [5:0] HALF_REF   = mpcs_half(`MPCS_REF_KHZ);
    localparam logic [5:0] HALF_RMII  = mpcs_half(`MPCS_RMII_KHZ);
    localparam logic [5:0] HALF_1000  = mpcs_half(`MPCS_RATE1000_KHZ);
    localparam logic [5:0] HALF_100   = mpcs_half(`MPCS_RATE100_KHZ);
    localparam logic [5:0] HALF_10    = mpcs_half(`MPCS_RATE10_KHZ);
    localparam logic [5:0] HALF_S125  = mpcs_half(`MPCS_SYNC125_KHZ);

    function automatic logic [5:0] mpcs_port_half(input mpcs_strap_t s, input logic f10);
        case (s.if_type)
            MPCS_IF_MII:   return f10 ? HALF_10 : HALF_100;
            MPCS_IF_RMII:  return HALF_RMII;
            MPCS_IF_RGMII: return f10 ? HALF_10 : (s.rgmii_1000 ? HALF_1000 : HALF_100);
            default:       return HALF_100;
        endcase
    endfunction

    function automatic logic [2:0] mpcs_src(input mpcs_oclk_t c);
        return {c.source_hi, c.source_lo};
    endfunction

    // Level of the selected recovered clock, low for the reference or an unused code
    function automatic logic mpcs_recov(input logic [2:0] src, input logic [`MPCS_NPHY-1:0] rc);
        if (src == 3'h0 || src > 3'(`MPCS_NPHY))
            return 1'b0;
        return rc[src - 3'h1];
    endfunction

    mpcs_state_t st_ff;
    mpcs_state_t nxt_st;

    always_comb
    begin
        logic [6:0] stp;
        logic [2:0] src;
        stp = '0;
        src = '0;
        nxt_st = st_ff;
        nxt_st.rdata = '0;
        // straps caught once, on the first edge after reset release
        if (!st_ff.strap_taken)
        begin
            nxt_st.strap = STRAP;
            nxt_st.strap_taken = 1'b1;
        end
        // management clock is only ever an input, seen as a level
        nxt_st.sclk = SERIAL_MGMT_CLK;
        nxt_st.rxc_in = PORT_RECEIVE_CLOCK_I;
        nxt_st.txc_in = PORT_TRANSMIT_CLOCK_I;
        if (REG_WR)
        begin
            case (REG_ADDR)
                `MPCS_OFS_OCLK:  nxt_st.oclk_req = REG_WDATA[4:0];
                // only software selects the 10 Mbps rate
                `MPCS_OFS_SPEED: nxt_st.force10 = REG_WDATA[`MPCS_NPORT-1:0];
                default:         nxt_st.oclk_req = st_ff.oclk_req;
            endcase
        end
        if (REG_RD)
        begin
            case (REG_ADDR)
                `MPCS_OFS_OCLK:  nxt_st.rdata[4:0] = st_ff.oclk_req;
                `MPCS_OFS_SPEED: nxt_st.rdata[`MPCS_NPORT-1:0] = st_ff.force10;
                `MPCS_OFS_STRAP:
                begin
                    for (int p = 0; p < `MPCS_NPORT; p++)
                        nxt_st.rdata[p*`MPCS_STRAP_STRIDE +: 5] = st_ff.strap[p];
                end
                `MPCS_OFS_STAT:
                begin
                    nxt_st.rdata[4:0] = st_ff.oclk_act;
                    nxt_st.rdata[`MPCS_STAT_PARK_BIT] = (st_ff.sst == MPCS_SS_PARK);
                    nxt_st.rdata[`MPCS_STAT_SCLK_BIT] = st_ff.sclk;
                    nxt_st.rdata[`MPCS_STAT_TXC_LSB +: `MPCS_NPORT] = st_ff.txc_in;
                    nxt_st.rdata[`MPCS_STAT_RXC_LSB +: `MPCS_NPORT] = st_ff.rxc_in;
                end
                default:         nxt_st.rdata = '0;
            endcase
        end
        // 25 MHz reference regenerated from the core clock for the PHY transmit paths
        stp = mpcs_step(st_ff.refdiv, HALF_REF);
        nxt_st.refdiv = stp[5:0];
        nxt_st.ref_out = st_ff.ref_out ^ stp[6];
        for (int p = 0; p < `MPCS_NPORT; p++)
        begin
            stp = mpcs_step(st_ff.pdiv[p], mpcs_port_half(st_ff.strap[p], st_ff.force10[p]));
            nxt_st.pdiv[p] = stp[5:0];
            nxt_st.pclk[p] = st_ff.pclk[p] ^ stp[6];
            nxt_st.rxc_oe_n[p] = 1'b1;
            nxt_st.txc_oe_n[p] = 1'b1;
            if (st_ff.strap_taken)
            begin
                case (st_ff.strap[p].if_type)
                    // PHY role drives both clocks, MAC role takes both in
                    MPCS_IF_MII:
                    begin
                        nxt_st.rxc_oe_n[p] = !st_ff.strap[p].mii_phy_role;
                        nxt_st.txc_oe_n[p] = !st_ff.strap[p].mii_phy_role;
                    end
                    // one 50 MHz reference, driven out only in clock mode
                    MPCS_IF_RMII: nxt_st.rxc_oe_n[p] = !st_ff.strap[p].rmii_clk_mode;
                    // receive clock out, transmit clock in
                    MPCS_IF_RGMII: nxt_st.rxc_oe_n[p] = 1'b0;
                    default:       nxt_st.rxc_oe_n[p] = 1'b1;
                endcase
            end
            nxt_st.rxc_o[p] = !nxt_st.rxc_oe_n[p] & nxt_st.pclk[p];
            nxt_st.txc_o[p] = !nxt_st.txc_oe_n[p] & nxt_st.pclk[p];
        end
        // new settings are taken only while the output is low, so no high phase is cut
        src = mpcs_src(st_ff.oclk_act);
        case (st_ff.sst)
            MPCS_SS_RUN:
            begin
                if (st_ff.oclk_req != st_ff.oclk_act && !st_ff.sync_out)
                begin
                    nxt_st.oclk_act = st_ff.oclk_req;
                    nxt_st.sdiv = '0;
                    nxt_st.sst = MPCS_SS_PARK;
                end
                else if (!st_ff.oclk_act.enable)
                    nxt_st.sync_out = 1'b0;
                else if (src == 3'h0)
                begin
                    stp = mpcs_step(st_ff.sdiv, st_ff.oclk_act.sel_125 ? HALF_S125 : HALF_REF);
                    nxt_st.sdiv = stp[5:0];
                    nxt_st.sync_out = st_ff.sync_out ^ stp[6];
                end
                else
                    nxt_st.sync_out = mpcs_recov(src, PHY_RECOVERED_CLK);
            end
            MPCS_SS_PARK:
            begin
                // Waiting for a low recovered clock keeps the first pulse whole
                nxt_st.sync_out = 1'b0;
                if (!mpcs_recov(src, PHY_RECOVERED_CLK))
                    nxt_st.sst = MPCS_SS_RUN;
            end
            default: nxt_st.sst = MPCS_SS_RUN;
        endcase
    end

    always_ff @(posedge SYS_CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            st_ff <= '0;
            st_ff.oclk_req <= `MPCS_OCLK_RESET;
            st_ff.oclk_act <= `MPCS_OCLK_RESET;
            st_ff.force10 <= `MPCS_SPEED_RESET;
            st_ff.rxc_oe_n <= '1;
            st_ff.txc_oe_n <= '1;
        end
        else
            st_ff <= nxt_st;
    end

    assign REG_RDATA                = st_ff.rdata;
    assign PORT_RECEIVE_CLOCK_O     = st_ff.rxc_o;
    assign PORT_RECEIVE_CLOCK_OE_N  = st_ff.rxc_oe_n;
    assign PORT_TRANSMIT_CLOCK_O    = st_ff.txc_o;
    assign PORT_TRANSMIT_CLOCK_OE_N = st_ff.txc_oe_n;
    assign PHY_TX_REF_CLK           = st_ff.ref_out;
    assign SYNC_ETH_CLOCK_OUT       = st_ff.sync_out;

    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RESETN);

    AST_STRAP_HOLD: assert property (st_ff.strap_taken |=> $stable(st_ff.strap))
        else $error("strap value changed after capture");
    AST_MII_PHY: assert property (st_ff.strap_taken && st_ff.strap[0].if_type == MPCS_IF_MII
        && st_ff.strap[0].mii_phy_role |=> !PORT_RECEIVE_CLOCK_OE_N[0] && !PORT_TRANSMIT_CLOCK_OE_N[0])
        else $error("MII PHY role does not drive both clocks");
    AST_MII_MAC: assert property (st_ff.strap_taken && st_ff.strap[0].if_type == MPCS_IF_MII
        && !st_ff.strap[0].mii_phy_role |=> PORT_RECEIVE_CLOCK_OE_N[0] && PORT_TRANSMIT_CLOCK_OE_N[0])
        else $error("MII MAC role drives a clock pin");
    AST_RMII_CLKMODE: assert property ($past(st_ff.strap_taken && st_ff.strap[0].if_type == MPCS_IF_RMII
        && st_ff.strap[0].rmii_clk_mode, 2) |-> !PORT_RECEIVE_CLOCK_OE_N[0]
        && PORT_RECEIVE_CLOCK_O[0] != $past(PORT_RECEIVE_CLOCK_O[0]))
        else $error("RMII clock mode reference not toggling at 50 MHz");
    AST_RMII_NORMAL: assert property (st_ff.strap_taken && st_ff.strap[0].if_type == MPCS_IF_RMII
        && !st_ff.strap[0].rmii_clk_mode |=> PORT_RECEIVE_CLOCK_OE_N[0] && PORT_TRANSMIT_CLOCK_OE_N[0])
        else $error("RMII normal mode drives a clock pin");
    AST_RGMII_DIR: assert property (st_ff.strap_taken && st_ff.strap[0].if_type == MPCS_IF_RGMII
        |=> !PORT_RECEIVE_CLOCK_OE_N[0] && PORT_TRANSMIT_CLOCK_OE_N[0])
        else $error("RGMII clock directions wrong");
    AST_RGMII_1000: assert property ($past(st_ff.strap[0].if_type == MPCS_IF_RGMII && st_ff.strap_taken
        && st_ff.strap[0].rgmii_1000 && !st_ff.force10[0], 2) && $past(!st_ff.force10[0])
        |-> PORT_RECEIVE_CLOCK_O[0] != $past(PORT_RECEIVE_CLOCK_O[0]))
        else $error("RGMII 1000 clock not at full rate");
    AST_REF_PERIOD: assert property ($rose(PHY_TX_REF_CLK) |-> ##1 PHY_TX_REF_CLK ##1 !PHY_TX_REF_CLK)
        else $error("PHY reference high time not two cycles");
    AST_SYNC_RECOV: assert property ($past(st_ff.sst == MPCS_SS_RUN && st_ff.oclk_act.enable
        && mpcs_src(st_ff.oclk_act) == 3'h1 && st_ff.oclk_req == st_ff.oclk_act)
        |-> SYNC_ETH_CLOCK_OUT == $past(PHY_RECOVERED_CLK[0]))
        else $error("sync output does not follow recovered clock");
    AST_SYNC_REF25: assert property ($rose(SYNC_ETH_CLOCK_OUT) && st_ff.oclk_act.enable
        && !st_ff.oclk_act.sel_125 && mpcs_src(st_ff.oclk_act) == 3'h0 |-> ##1 SYNC_ETH_CLOCK_OUT ##1 !SYNC_ETH_CLOCK_OUT)
        else $error("sync 25 MHz high time wrong");
    AST_SYNC_OFF: assert property (!st_ff.oclk_act.enable |-> !SYNC_ETH_CLOCK_OUT)
        else $error("disabled sync output is high");
    AST_SYNC_NOGLITCH: assert property (!$stable(st_ff.oclk_act) |-> !SYNC_ETH_CLOCK_OUT
        && $past(!SYNC_ETH_CLOCK_OUT))
        else $error("sync setting changed during a high phase");

    COV_SYNC_SWITCH: cover property (!$stable(st_ff.oclk_act) ##[1:20] $rose(SYNC_ETH_CLOCK_OUT));
    COV_RMII_CLKMODE: cover property (st_ff.strap_taken && st_ff.strap[0].if_type == MPCS_IF_RMII
        && st_ff.strap[0].rmii_clk_mode);
    COV_RGMII_10: cover property (st_ff.strap[1].if_type == MPCS_IF_RGMII && st_ff.force10[1]
        && $rose(PORT_RECEIVE_CLOCK_O[1]));

endmodule // mpcs_clock_select

/* File: pkg/mpcs_params.svh */
// Constants of the MAC port clock select block: frequencies, offsets, fields, resets.
// Assumes the core clock SYS_CLK is the multiplied reference at 100 MHz.
`ifndef MPCS_PARAMS_SVH
`define MPCS_PARAMS_SVH

`define MPCS_NPORT          2
`define MPCS_NPHY           5
`define MPCS_SYS_KHZ        100000
`define MPCS_REF_KHZ        25000
`define MPCS_RMII_KHZ       50000
`define MPCS_RATE1000_KHZ   125000
`define MPCS_RATE100_KHZ    25000
`define MPCS_RATE10_KHZ     2500
`define MPCS_SYNC125_KHZ    125000

`define MPCS_OFS_OCLK       8'h00
`define MPCS_OFS_SPEED      8'h04
`define MPCS_OFS_STRAP      8'h08
`define MPCS_OFS_STAT       8'h0C

`define MPCS_OCLK_EN_BIT    0
`define MPCS_OCLK_125_BIT   1
`define MPCS_OCLK_SRC_LSB   2
`define MPCS_OCLK_RESET     5'h01
`define MPCS_SPEED_RESET    2'h0
`define MPCS_STRAP_STRIDE   8
`define MPCS_STAT_PARK_BIT  5
`define MPCS_STAT_SCLK_BIT  6
`define MPCS_STAT_TXC_LSB   8
`define MPCS_STAT_RXC_LSB   10

`endif

/* File: pkg/mpcs_pkg.sv */
// Types of the MAC port clock select block.
// Assumes mpcs_params.svh is on the include path.
`include "mpcs_params.svh"

package mpcs_pkg;

    typedef enum logic [1:0] {MPCS_IF_MII, MPCS_IF_RMII, MPCS_IF_RGMII} mpcs_if_t;

    typedef struct packed {
        logic     rgmii_1000;
        logic     rmii_clk_mode;
        logic     mii_phy_role;
        mpcs_if_t if_type;
    } mpcs_strap_t;

    typedef struct packed {
        logic       source_hi;
        logic [1:0] source_lo;
        logic       sel_125;
        logic       enable;
    } mpcs_oclk_t;

    typedef enum logic {MPCS_SS_RUN, MPCS_SS_PARK} mpcs_sync_st_t;

    typedef struct packed {
        logic                               strap_taken;
        mpcs_strap_t [`MPCS_NPORT-1:0]      strap;
        logic [`MPCS_NPORT-1:0]             force10;
        mpcs_oclk_t                         oclk_req;
        mpcs_oclk_t                         oclk_act;
        mpcs_sync_st_t                      sst;
        logic [5:0]                         sdiv;
        logic                               sync_out;
        logic [5:0]                         refdiv;
        logic                               ref_out;
        logic [`MPCS_NPORT-1:0][5:0]        pdiv;
        logic [`MPCS_NPORT-1:0]             pclk;
        logic [`MPCS_NPORT-1:0]             rxc_o;
        logic [`MPCS_NPORT-1:0]             rxc_oe_n;
        logic [`MPCS_NPORT-1:0]             txc_o;
        logic [`MPCS_NPORT-1:0]             txc_oe_n;
        logic [`MPCS_NPORT-1:0]             rxc_in;
        logic [`MPCS_NPORT-1:0]             txc_in;
        logic                               sclk;
        logic [31:0]                        rdata;
    } mpcs_state_t;

endpackage

/* File: bench/mpcs_far_end.sv */
// Far-side MAC or PHY model of one external port: sources the clocks the straps hand to it.
// Assumes SYS_CLK timing; resolves each clock pin from both parties and feeds it back.
`timescale 1ns/1ps

module mpcs_far_end
#(
    parameter int HALF = 1
)
(
    // Clock and reset
    input  wire logic                 clk,
    input  wire logic                 rst_n,
    // Device side of the pins
    input  wire mpcs_pkg::mpcs_strap_t strap,
    input  wire logic                 dev_rx,
    input  wire logic                 dev_rx_oe_n,
    input  wire logic                 dev_tx,
    input  wire logic                 dev_tx_oe_n,
    // Resolved pin levels
    output logic                      rx_pin,
    output logic                      tx_pin
);
    import mpcs_pkg::*;
    logic [7:0] cnt_ff;
    logic       clk_ff;
    logic       rx_last_ff;
    logic       tx_last_ff;
    logic       far_rx;
    logic       far_tx;
    // far PHY drives both clocks when the device is the MII MAC
    assign far_rx = (strap.if_type == MPCS_IF_MII) && !strap.mii_phy_role;
    // far end sources the shared RMII reference outside clock mode, or the RGMII transmit clock
    assign far_tx = far_rx || (strap.if_type == MPCS_IF_RGMII) ||
                    ((strap.if_type == MPCS_IF_RMII) && !strap.rmii_clk_mode);
    // Contention shows as unknown; a released pin flips every cycle so no stale level passes
    assign rx_pin = !dev_rx_oe_n ? (far_rx ? 1'bx : dev_rx) : (far_rx ? clk_ff : ~rx_last_ff);
    assign tx_pin = !dev_tx_oe_n ? (far_tx ? 1'bx : dev_tx) : (far_tx ? clk_ff : ~tx_last_ff);
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt_ff <= 8'h00;
            clk_ff <= 1'b0;
            rx_last_ff <= 1'b0;
            tx_last_ff <= 1'b0;
        end
        else
        begin
            cnt_ff <= (cnt_ff == 8'(HALF - 1)) ? 8'h00 : cnt_ff + 8'h01;
            clk_ff <= (cnt_ff == 8'(HALF - 1)) ? ~clk_ff : clk_ff;
            rx_last_ff <= rx_pin;
            tx_last_ff <= tx_pin;
        end
    end
endmodule // mpcs_far_end

/* File: bench/mpcs_clock_select_tb_top.sv */
// Testbench of the MAC port clock select block: strap configurations, registers, sync output.
// Assumes the far-end model in mpcs_far_end.sv and the design package on the include path.
`timescale 1ns/1ps
`include "mpcs_params.svh"

module mpcs_clock_select_tb_top;
    import mpcs_pkg::*;
    logic              sys_clk = 1'b0;
    logic              resetn = 1'b0;
    logic [7:0]        addr = 8'h00;
    logic [31:0]       wdata = 32'h0;
    logic              wr = 1'b0;
    logic              rd = 1'b0;
    logic              mgmt = 1'b0;
    logic [31:0]       rdata;
    logic [31:0]       d;
    mpcs_strap_t [1:0] strap = 10'h000;
    logic [1:0]        rx_pin, rx_o, rx_oe_n, tx_pin, tx_o, tx_oe_n;
    logic              sync_out, tx_ref, rec_clk = 1'b0, prev;
    logic [2:0]        rec_sel = 3'h0;
    logic [4:0]        phy_rec;
    logic [5:0]        mon;
    int                mismatches = 0, compares = 0;
    // Straps {port1, port0}, expected OE_N {tx1,tx0,rx1,rx0}, half periods rx0,rx1,tx0,tx1
    logic [9:0]        cfg [4] = '{{5'h12, 5'h04}, {5'h09, 5'h00}, {5'h03, 5'h01}, {5'h04, 5'h02}};
    logic [3:0]        oe_exp [4] = '{4'h8, 4'hD, 4'hF, 4'h4};
    int                hp [4][4] = '{'{2, 1, 2, 0}, '{0, 1, 0, 0}, '{0, 0, 0, 0}, '{2, 2, 0, 2}};

    always #5 sys_clk = ~sys_clk;
    assign mon = {sync_out, tx_ref, tx_o, rx_o};
    assign phy_rec = rec_clk ? (5'h01 << rec_sel) : 5'h00;
    always @(posedge sys_clk)
        if ($time % 80 == 35) rec_clk <= ~rec_clk;

    mpcs_clock_select i_dut (.SYS_CLK(sys_clk), .RESETN(resetn), .REG_ADDR(addr), .REG_WDATA(wdata),
        .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata), .STRAP(strap), .PORT_RECEIVE_CLOCK_I(rx_pin),
        .PORT_RECEIVE_CLOCK_O(rx_o), .PORT_RECEIVE_CLOCK_OE_N(rx_oe_n), .PORT_TRANSMIT_CLOCK_I(tx_pin),
        .PORT_TRANSMIT_CLOCK_O(tx_o), .PORT_TRANSMIT_CLOCK_OE_N(tx_oe_n), .PHY_RECOVERED_CLK(phy_rec),
        .SERIAL_MGMT_CLK(mgmt), .PHY_TX_REF_CLK(tx_ref), .SYNC_ETH_CLOCK_OUT(sync_out));
    for (genvar p = 0; p < 2; p++)
    begin : g_far
        mpcs_far_end #(.HALF(p * 2 + 1)) i_far (.clk(sys_clk), .rst_n(resetn), .strap(strap[p]),
            .dev_rx(rx_o[p]), .dev_rx_oe_n(rx_oe_n[p]), .dev_tx(tx_o[p]), .dev_tx_oe_n(tx_oe_n[p]),
            .rx_pin(rx_pin[p]), .tx_pin(tx_pin[p]));
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string nm);
        compares++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
        @(posedge sys_clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= v;
        @(posedge sys_clk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] a);
        @(posedge sys_clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge sys_clk);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask
    // Waits for one change of a watched clock, then counts cycles to the next one
    task automatic half(input int k, input int exp, input string nm);
        int n;
        logic v;
        @(posedge sys_clk);
        #1;
        for (int e = 0; e < 2; e++)
        begin
            v = mon[k];
            n = 0;
            while (mon[k] === v && n < 60)
            begin
                @(posedge sys_clk);
                #1;
                n++;
            end
        end
        chk(n, exp, nm);
    endtask
    task automatic do_reset(input logic [9:0] s);
        @(posedge sys_clk);
        resetn <= 1'b0;
        strap <= s;
        repeat (16) @(posedge sys_clk);
        #1;
        chk({rx_oe_n, tx_oe_n}, 4'hF, "oe_in_reset");
        chk(mon, 6'h00, "clk_in_reset");
        chk(rdata, 32'h0, "rdata_in_reset");
        @(posedge sys_clk);
        resetn <= 1'b1;
        repeat (4) @(posedge sys_clk);
    endtask
    task automatic end_sim;
        $display("Comparisons %0d, mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    initial
    begin
        repeat (20000) @(posedge sys_clk);
        mismatches++;
        end_sim;
    end

    initial
    begin
        for (int c = 0; c < 4; c++)
        begin
            do_reset(cfg[c]);
            #1;
            chk({tx_oe_n, rx_oe_n}, oe_exp[c], "pin_dir");
            rd_reg(`MPCS_OFS_STRAP);
            chk(d, {19'h0, cfg[c][9:5], 3'h0, cfg[c][4:0]}, "strap_stat");
            for (int k = 0; k < 4; k++)
                if (!oe_exp[c][k]) half(k, hp[c][k], "port_half");
                else chk(mon[k], 1'b0, "undriven_low");
            $display("test straps config %0d done", c);
        end
        rd_reg(`MPCS_OFS_SPEED);
        chk(d, 32'h0, "speed_reset");
        wr_reg(`MPCS_OFS_SPEED, 32'h3);
        rd_reg(`MPCS_OFS_SPEED);
        chk(d, 32'h3, "speed_rw");
        half(0, 20, "rgmii10_half");
        half(1, 20, "mii10_rx_half");
        half(3, 20, "mii10_tx_half");
        wr_reg(`MPCS_OFS_STRAP, 32'hFFFF);
        wr_reg(8'h10, 32'h5);
        rd_reg(`MPCS_OFS_STRAP);
        chk(d, {19'h0, cfg[3][9:5], 3'h0, cfg[3][4:0]}, "strap_ro");
        rd_reg(8'h10);
        chk(d, 32'h0, "unmapped");
        $display("test registers done");
        for (int v = 1; v >= 0; v--)
        begin
            mgmt <= v[0];
            repeat (4) @(posedge sys_clk);
            rd_reg(`MPCS_OFS_STAT);
            chk(d[6], v[0], "mgmt_clk_in");
            chk(d[31:12], 20'h0, "stat_unused");
            chk(d[4:0], 5'h01, "stat_sync_default");
            chk(d[5], 1'b0, "stat_parked");
            chk($isunknown(d[11:8]), 1'b0, "pin_contention");
        end
        rd_reg(`MPCS_OFS_OCLK);
        chk(d, 32'h1, "oclk_reset");
        half(4, 2, "phy_tx_ref_half");
        half(5, 2, "sync25_half");
        wr_reg(`MPCS_OFS_OCLK, 32'h3);
        // A switch may wait out a high phase and a park cycle first
        repeat (8) @(posedge sys_clk);
        half(5, 1, "sync125_half");
        wr_reg(`MPCS_OFS_OCLK, 32'h0);
        repeat (8) @(posedge sys_clk);
        #1;
        for (int i = 0; i < 16; i++)
        begin
            chk(sync_out, 1'b0, "sync_disabled");
            @(posedge sys_clk);
            #1;
        end
        for (int p = 1; p <= 5; p++)
        begin
            rec_sel <= 3'(p - 1);
            wr_reg(`MPCS_OFS_OCLK, 32'(p << `MPCS_OCLK_SRC_LSB) | 32'h1);
            rd_reg(`MPCS_OFS_OCLK);
            chk(d, 32'(p << `MPCS_OCLK_SRC_LSB) | 32'h1, "oclk_rw");
            repeat (24) @(posedge sys_clk);
            #1;
            prev = phy_rec[p - 1];
            for (int i = 0; i < 12; i++)
            begin
                @(posedge sys_clk);
                #1;
                chk(sync_out, prev, "sync_recovered");
                prev = phy_rec[p - 1];
            end
        end
        $display("test sync output done");
        end_sim;
    end
endmodule // mpcs_clock_select_tb_top
